//--- hdl/sdma_pkg.sv
`default_nettype none

package sdma_pkg;

  // ----------------------------------------
  // Special-function register addresses
  // ----------------------------------------
  localparam logic [7:0] ADDR_PTR0_LOW = 8'h82;
  localparam logic [7:0] ADDR_PTR0_HIGH = 8'h83;
  localparam logic [7:0] ADDR_PTR1_LOW = 8'h84;
  localparam logic [7:0] ADDR_PTR1_HIGH = 8'h85;
  localparam logic [7:0] ADDR_PTR_SELECT = 8'h86;
  localparam logic [7:0] ADDR_CLOCK_CONTROL = 8'h8E;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int SELECT_BIT = 0;
  localparam int STRETCH_MSB = 2;
  localparam int STRETCH_LSB = 0;
  localparam logic [7:0] CLOCK_CONTROL_RESET = 8'h01;
  localparam logic [15:0] POINTER_RESET = 16'h0000;
  localparam logic SELECT_RESET = 1'b0;

  // ----------------------------------------
  // Bus timing counts, in clocks; MOVE_BASE_CYCLES is in machine cycles
  // ----------------------------------------
  localparam int CLKS_PER_CYCLE = 4;
  localparam logic [5:0] ALE_CLKS = 6'h02;
  localparam logic [5:0] STROBE_START = 6'h04;
  localparam logic [5:0] STROBE_ZERO_WIDTH = 6'h02;
  localparam logic [5:0] STROBE_STEP = 6'h04;
  localparam logic [5:0] MOVE_BASE_CYCLES = 6'h02;
  localparam logic [5:0] FETCH_CLKS = 6'h04;
  localparam logic [5:0] PSEN_START = 6'h02;
  localparam int SYNC_STAGES = 3;

  // Bus sequencer states
  typedef enum logic [1:0] {
    SDMA_IDLE,
    SDMA_FETCH,
    SDMA_MOVE
  } sdma_state_t;

endpackage

`default_nettype wire

//--- hdl/sdma_ptr_if.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Link between register logic and pointer bank
// ----------------------------------------
interface sdma_ptr_if;
  logic sel;
  logic load;
  logic inc;
  logic [15:0] load_value;
  logic byte_wr;
  logic [1:0] byte_idx;
  logic [7:0] byte_data;
  logic [15:0] ptr0;
  logic [15:0] ptr1;

  modport ctl (output sel, load, inc, load_value, byte_wr, byte_idx, byte_data, input ptr0, ptr1);
  modport bank (input sel, load, inc, load_value, byte_wr, byte_idx, byte_data, output ptr0, ptr1);
endinterface

`default_nettype wire

//--- hdl/sdma_phase.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Machine cycle divider
// ----------------------------------------
module sdma_phase #(
  parameter int CLKS = sdma_pkg::CLKS_PER_CYCLE
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  output logic cycle_last
);
  logic [3:0] phase_q;

  // Counts clocks of a machine cycle, pulses on its last clock
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      phase_q <= 4'h0;
    end
    else if (phase_q == 4'(CLKS - 1))
    begin
      phase_q <= 4'h0;
    end
    else
    begin
      phase_q <= phase_q + 4'h1;
    end
  end

  assign cycle_last = (phase_q == 4'(CLKS - 1));
endmodule

`default_nettype wire

//--- hdl/sdma_ptr_bank.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Dual data pointer bank
// ----------------------------------------
module sdma_ptr_bank (
  input wire logic clk_sys,
  input wire logic reset_n,
  sdma_ptr_if.bank pif
);
  logic [15:0] ptr_q [2];

  // One pointer per slot; load and increment hit only the selected one
  for (genvar i = 0; i < 2; i++)
  begin : g_ptr
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
      if (!reset_n)
      begin
        ptr_q[i] <= sdma_pkg::POINTER_RESET;
      end
      else if (pif.load && (pif.sel == 1'(i)))
      begin
        ptr_q[i] <= pif.load_value;
      end
      else if (pif.inc && (pif.sel == 1'(i)))
      begin
        ptr_q[i] <= ptr_q[i] + 16'h0001;
      end
      else if (pif.byte_wr && (pif.byte_idx[1] == 1'(i)))
      begin
        if (pif.byte_idx[0])
        begin
          ptr_q[i][15:8] <= pif.byte_data;
        end
        else
        begin
          ptr_q[i][7:0] <= pif.byte_data;
        end
      end
    end
  end

  assign pif.ptr0 = ptr_q[0];
  assign pif.ptr1 = ptr_q[1];
endmodule

`default_nettype wire

//--- hdl/sdma_top.sv
`timescale 1ns/1ps
`default_nettype none

module sdma_top (
  input wire logic clk_sys,
  input wire logic reset_n,
  // Special-function register port from the core
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  // Pointer operations from the core
  input wire logic ptr_load,
  input wire logic [15:0] ptr_load_value,
  input wire logic ptr_inc,
  output logic [15:0] data_pointer,
  // Data move request
  input wire logic move_req,
  input wire logic move_write,
  input wire logic move_use_ptr,
  input wire logic [7:0] move_page,
  input wire logic [7:0] move_reg_addr,
  input wire logic [7:0] move_wdata,
  output logic move_busy,
  output logic move_done,
  output logic [7:0] move_rdata,
  // Program fetch request
  input wire logic fetch_req,
  input wire logic [15:0] fetch_addr,
  output logic fetch_done,
  output logic [7:0] fetch_data,
  // External bus
  input wire logic [7:0] low_port_in,
  output logic [7:0] low_port_out,
  output logic low_port_oe,
  output logic [7:0] high_port_out,
  output logic ale,
  output logic rd_n,
  output logic wr_n,
  output logic psen_n
);

  // ----------------------------------------
  // Timing decode
  // ----------------------------------------

  // Clock after the last strobe clock for a stretch value
  function automatic logic [5:0] strobe_end(input logic [2:0] st);
    if (st == 3'h0)
      strobe_end = sdma_pkg::STROBE_START + sdma_pkg::STROBE_ZERO_WIDTH;
    else
      strobe_end = sdma_pkg::STROBE_START + 6'(st) * sdma_pkg::STROBE_STEP;
  endfunction

  // Whole data move length in clocks
  function automatic logic [5:0] move_len(input logic [2:0] st);
    move_len = (6'(st) + sdma_pkg::MOVE_BASE_CYCLES) * 6'(sdma_pkg::CLKS_PER_CYCLE);
  endfunction

  // ----------------------------------------
  // Submodules
  // ----------------------------------------
  logic cycle_last;
  sdma_ptr_if pif ();

  sdma_phase #(
    .CLKS(sdma_pkg::CLKS_PER_CYCLE)
  ) u_phase (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .cycle_last(cycle_last)
  );

  sdma_ptr_bank u_bank (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .pif(pif)
  );

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic sel_q;
  logic [7:0] clock_control_q;
  logic sfr_hit_ptr;
  logic [15:0] active_ptr;

  assign sfr_hit_ptr = sfr_wr && (sfr_addr >= sdma_pkg::ADDR_PTR0_LOW) && (sfr_addr <= sdma_pkg::ADDR_PTR1_HIGH);
  assign active_ptr = sel_q ? pif.ptr1 : pif.ptr0;

  // Pointer bank control
  assign pif.sel = sel_q;
  assign pif.load = ptr_load;
  assign pif.inc = ptr_inc && !ptr_load;
  assign pif.load_value = ptr_load_value;
  assign pif.byte_wr = sfr_hit_ptr && !ptr_load && !ptr_inc;
  assign pif.byte_idx = 2'(sfr_addr - sdma_pkg::ADDR_PTR0_LOW);
  assign pif.byte_data = sfr_wdata;

  // Select bit; a write stores data bit 0, upper bits dropped
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      sel_q <= sdma_pkg::SELECT_RESET;
    else if (sfr_wr && (sfr_addr == sdma_pkg::ADDR_PTR_SELECT))
      sel_q <= sfr_wdata[sdma_pkg::SELECT_BIT];
  end

  // Clock control, writable at any time
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      clock_control_q <= sdma_pkg::CLOCK_CONTROL_RESET;
    else if (sfr_wr && (sfr_addr == sdma_pkg::ADDR_CLOCK_CONTROL))
      clock_control_q <= sfr_wdata;
  end

  // Registered read data; unmapped addresses read zero
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sfr_rdata <= 8'h00;
    end
    else if (sfr_rd)
    begin
      unique case (sfr_addr)
        sdma_pkg::ADDR_PTR0_LOW: sfr_rdata <= pif.ptr0[7:0];
        sdma_pkg::ADDR_PTR0_HIGH: sfr_rdata <= pif.ptr0[15:8];
        sdma_pkg::ADDR_PTR1_LOW: sfr_rdata <= pif.ptr1[7:0];
        sdma_pkg::ADDR_PTR1_HIGH: sfr_rdata <= pif.ptr1[15:8];
        sdma_pkg::ADDR_PTR_SELECT: sfr_rdata <= {7'h00, sel_q};
        sdma_pkg::ADDR_CLOCK_CONTROL: sfr_rdata <= clock_control_q;
        default: sfr_rdata <= 8'h00;
      endcase
    end
  end

  // Active pointer copy for the core
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      data_pointer <= sdma_pkg::POINTER_RESET;
    else
      data_pointer <= active_ptr;
  end

  // ----------------------------------------
  // Low port input filter
  // ----------------------------------------
  logic [7:0] in_s1_q;
  logic [7:0] in_s2_q;
  logic [7:0] in_s3_q;
  logic [7:0] in_q;

  // Three stages; value taken once stages two and three agree
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      in_s1_q <= 8'h00;
      in_s2_q <= 8'h00;
      in_s3_q <= 8'h00;
      in_q <= 8'h00;
    end
    else
    begin
      in_s1_q <= low_port_in;
      in_s2_q <= in_s1_q;
      in_s3_q <= in_s2_q;
      if (in_s2_q == in_s3_q)
        in_q <= in_s3_q;
    end
  end

  // ----------------------------------------
  // Bus sequencer
  // ----------------------------------------
  sdma_pkg::sdma_state_t state_q;
  sdma_pkg::sdma_state_t state_d;
  logic [5:0] cnt_q;
  logic [5:0] cnt_d;
  logic [2:0] st_q;
  logic wr_q;
  logic [15:0] addr_q;
  logic [7:0] wdata_q;
  logic start_move;
  logic start_fetch;
  logic [sdma_pkg::SYNC_STAGES-1:0] fetch_wait_q;

  // Requests begin only on a machine cycle boundary
  assign start_move = (state_q == sdma_pkg::SDMA_IDLE) && cycle_last && move_req;
  assign start_fetch = (state_q == sdma_pkg::SDMA_IDLE) && cycle_last && fetch_req && !move_req;

  // Next state and clock count
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q + 6'h01;
    unique case (state_q)
      sdma_pkg::SDMA_IDLE:
      begin
        cnt_d = 6'h00;
        if (start_move)
          state_d = sdma_pkg::SDMA_MOVE;
        else if (start_fetch)
          state_d = sdma_pkg::SDMA_FETCH;
      end
      sdma_pkg::SDMA_FETCH:
      begin
        if (cnt_q == sdma_pkg::FETCH_CLKS - 6'h01)
          state_d = sdma_pkg::SDMA_IDLE;
      end
      sdma_pkg::SDMA_MOVE:
      begin
        if (cnt_q == move_len(st_q) - 6'h01)
          state_d = sdma_pkg::SDMA_IDLE;
      end
    endcase
  end

  // State, count and latched request
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q <= sdma_pkg::SDMA_IDLE;
      cnt_q <= 6'h00;
      st_q <= 3'h0;
      wr_q <= 1'b0;
      addr_q <= 16'h0000;
      wdata_q <= 8'h00;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      if (start_move)
      begin
        st_q <= clock_control_q[sdma_pkg::STRETCH_MSB:sdma_pkg::STRETCH_LSB];
        wr_q <= move_write;
        addr_q <= move_use_ptr ? active_ptr : {move_page, move_reg_addr};
        wdata_q <= move_wdata;
      end
      else if (start_fetch)
        addr_q <= fetch_addr;
    end
  end

  // Pins follow the next state so timing aligns to the cycle start
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ale <= 1'b0;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      psen_n <= 1'b1;
      low_port_out <= 8'h00;
      low_port_oe <= 1'b0;
      high_port_out <= 8'h00;
    end
    else
    begin
      ale <= (state_d != sdma_pkg::SDMA_IDLE) && (cnt_d < sdma_pkg::ALE_CLKS);
      psen_n <= !((state_d == sdma_pkg::SDMA_FETCH) && (cnt_d >= sdma_pkg::PSEN_START));
      rd_n <= !((state_d == sdma_pkg::SDMA_MOVE) && !wr_q && (cnt_d >= sdma_pkg::STROBE_START)
               && (cnt_d < strobe_end(st_q)));
      wr_n <= !((state_d == sdma_pkg::SDMA_MOVE) && wr_q && (cnt_d >= sdma_pkg::STROBE_START)
               && (cnt_d < strobe_end(st_q)));
      if (state_d == sdma_pkg::SDMA_IDLE)
        low_port_oe <= 1'b0;
      else if (cnt_d < sdma_pkg::ALE_CLKS)
      begin
        low_port_out <= (state_q == sdma_pkg::SDMA_IDLE) ? (start_move && move_use_ptr ? active_ptr[7:0]
                        : start_move ? move_reg_addr : fetch_addr[7:0]) : addr_q[7:0];
        high_port_out <= (state_q == sdma_pkg::SDMA_IDLE) ? (start_move && move_use_ptr ? active_ptr[15:8]
                         : start_move ? move_page : fetch_addr[15:8]) : addr_q[15:8];
        low_port_oe <= 1'b1;
      end
      else
      begin
        low_port_out <= wdata_q;
        low_port_oe <= (state_d == sdma_pkg::SDMA_MOVE) && wr_q;
      end
    end
  end

  // Read capture and completion pulses; a fetch is only two strobe clocks long,
  // so its byte is taken once it has crossed the input filter, after the bus cycle
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      move_rdata <= 8'h00;
      fetch_data <= 8'h00;
      move_done <= 1'b0;
      fetch_done <= 1'b0;
      move_busy <= 1'b0;
      fetch_wait_q <= {sdma_pkg::SYNC_STAGES{1'b0}};
    end
    else
    begin
      move_busy <= (state_d == sdma_pkg::SDMA_MOVE);
      move_done <= (state_q == sdma_pkg::SDMA_MOVE) && (state_d == sdma_pkg::SDMA_IDLE);
      fetch_wait_q <= {fetch_wait_q[sdma_pkg::SYNC_STAGES-2:0],
                       (state_q == sdma_pkg::SDMA_FETCH) && (state_d == sdma_pkg::SDMA_IDLE)};
      fetch_done <= fetch_wait_q[sdma_pkg::SYNC_STAGES-1];
      if ((state_q == sdma_pkg::SDMA_MOVE) && !wr_q && (cnt_q == strobe_end(st_q)))
        move_rdata <= in_q;
      if (fetch_wait_q[sdma_pkg::SYNC_STAGES-1])
        fetch_data <= in_q;
    end
  end

endmodule

`default_nettype wire

//--- tb/sdma_assertions.sv
`timescale 1ns/1ps
`default_nettype none

module sdma_checker (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_rdata,
  input wire logic move_busy,
  input wire logic move_done,
  input wire logic fetch_done,
  input wire logic low_port_oe,
  input wire logic ale,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic psen_n
);
  // ----------------------------------------
  // Bus timing and register checks
  // ----------------------------------------
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  property p_ale_width; $rose(ale) |=> ale ##1 !ale; endproperty
  a_ale_width: assert property (p_ale_width) else $error("ale width wrong");
  property p_ale_drive; ale |-> low_port_oe; endproperty
  a_ale_drive: assert property (p_ale_drive) else $error("address not driven with ale");
  property p_rd_float; !rd_n |-> !low_port_oe; endproperty
  a_rd_float: assert property (p_rd_float) else $error("low port driven in read");
  property p_wr_drive; !wr_n |-> low_port_oe; endproperty
  a_wr_drive: assert property (p_wr_drive) else $error("low port idle in write");
  property p_fetch_len; $fell(psen_n) |=> !psen_n ##1 psen_n; endproperty
  a_fetch_len: assert property (p_fetch_len) else $error("fetch strobe width wrong");
  property p_fetch_done; $fell(psen_n) |-> ##5 fetch_done; endproperty
  a_fetch_done: assert property (p_fetch_done) else $error("fetch done late");
  property p_strobe; $fell(rd_n) |=> !rd_n ##[1:27] rd_n; endproperty
  a_strobe: assert property (p_strobe) else $error("read strobe width out of range");
  property p_move_len; $rose(move_busy) |-> ##[8:37] move_done; endproperty
  a_move_len: assert property (p_move_len) else $error("data move too long");
  property p_sel_zero; sfr_rd && sfr_addr == sdma_pkg::ADDR_PTR_SELECT |=> sfr_rdata[7:1] == 7'h00; endproperty
  a_sel_zero: assert property (p_sel_zero) else $error("select upper bits set");

  // Main scenarios reached
  c_read: cover property ($fell(rd_n));
  c_write: cover property ($fell(wr_n));
  c_fetch: cover property (fetch_done);
endmodule

bind sdma_top sdma_checker sdma_checker_i (.clk_sys(clk_sys), .reset_n(reset_n), .sfr_addr(sfr_addr),
  .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .move_busy(move_busy), .move_done(move_done),
  .fetch_done(fetch_done), .low_port_oe(low_port_oe), .ale(ale), .rd_n(rd_n), .wr_n(wr_n), .psen_n(psen_n));

`default_nettype wire

//--- tb/sdma_mem_model.sv
`timescale 1ns/1ps
`default_nettype none

module sdma_mem_model (
  input wire logic clk_sys,
  input wire logic slow,
  input wire logic ale,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic psen_n,
  input wire logic low_port_oe,
  input wire logic [7:0] low_port_out,
  input wire logic [7:0] high_port_out,
  output logic [7:0] low_port_in
);
  // ----------------------------------------
  // External memory and code store
  // ----------------------------------------
  logic [7:0] mem [0:255];
  logic [15:0] addr_q = 16'h0000;
  logic [7:0] last_q = 8'h00;
  logic code_q = 1'b0;
  logic drive;
  int low_cnt = 0;
  int rel_cnt = 99;

  // Latch address, store writes, time the strobe and the hold
  always @(posedge clk_sys)
  begin
    if (ale)
      addr_q <= {high_port_out, low_port_out};
    if (ale || !rd_n || !psen_n)
      rel_cnt <= 0;
    else
      rel_cnt <= rel_cnt + 1;
    code_q <= ale ? 1'b0 : (code_q | !psen_n);
    low_cnt <= rd_n ? 0 : low_cnt + 1;
    if (!wr_n)
      mem[addr_q[7:0]] <= low_port_out;
    last_q <= low_port_in;
  end

  // Slow mode answers late; a released bus shows a changing pattern
  assign drive = !low_port_oe && rel_cnt < 4 && (!slow || low_cnt >= 4 || !psen_n || code_q);
  assign low_port_in = !drive ? ~last_q : (code_q || !psen_n) ? addr_q[7:0] ^ addr_q[15:8] ^ 8'h3C :
    mem[addr_q[7:0]];
endmodule

`default_nettype wire

//--- tb/sdma_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module sdma_tb_top;
  logic clk_sys, reset_n, sfr_wr, sfr_rd, ptr_load, ptr_inc, move_req, move_write, move_use_ptr, fetch_req, slow;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, move_page, move_reg_addr, move_wdata, move_rdata, fetch_data;
  logic [7:0] low_port_in, low_port_out, high_port_out, d;
  logic [15:0] ptr_load_value, fetch_addr, data_pointer, a;
  logic move_busy, move_done, fetch_done, low_port_oe, ale, rd_n, wr_n, psen_n;
  int bad_count = 0;
  int n_checks = 0;
  int em [256];
  int pm [2];
  int pb [4];
  int sel = 0;

  sdma_top sdma_top_i (.clk_sys(clk_sys), .reset_n(reset_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .ptr_load(ptr_load),
    .ptr_load_value(ptr_load_value), .ptr_inc(ptr_inc), .data_pointer(data_pointer), .move_req(move_req),
    .move_write(move_write), .move_use_ptr(move_use_ptr), .move_page(move_page), .move_reg_addr(move_reg_addr),
    .move_wdata(move_wdata), .move_busy(move_busy), .move_done(move_done), .move_rdata(move_rdata),
    .fetch_req(fetch_req), .fetch_addr(fetch_addr), .fetch_done(fetch_done), .fetch_data(fetch_data),
    .low_port_in(low_port_in), .low_port_out(low_port_out), .low_port_oe(low_port_oe),
    .high_port_out(high_port_out), .ale(ale), .rd_n(rd_n), .wr_n(wr_n), .psen_n(psen_n));
  sdma_mem_model sdma_mem_model_i (.clk_sys(clk_sys), .slow(slow), .ale(ale), .rd_n(rd_n), .wr_n(wr_n),
    .psen_n(psen_n), .low_port_oe(low_port_oe), .low_port_out(low_port_out), .high_port_out(high_port_out),
    .low_port_in(low_port_in));

  // ----------------------------------------
  // Clock and shared tasks
  // ----------------------------------------
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic finish_test();
    if (bad_count == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic sfr_w(input logic [7:0] ad, input logic [7:0] wd);
    @(negedge clk_sys);
    sfr_addr = ad;
    sfr_wdata = wd;
    sfr_wr = 1'b1;
    @(negedge clk_sys);
    sfr_wr = 1'b0;
  endtask

  task automatic sfr_r(input logic [7:0] ad, input int e);
    @(negedge clk_sys);
    sfr_addr = ad;
    sfr_rd = 1'b1;
    @(negedge clk_sys);
    sfr_rd = 1'b0;
    chk("sfr_rdata", 16'(e), {8'h00, sfr_rdata});
  endtask

  // Pointer load or increment, then the selected copy is compared
  task automatic ptr_op(input bit ld, input logic [15:0] v);
    @(negedge clk_sys);
    ptr_load = ld;
    ptr_inc = !ld;
    ptr_load_value = v;
    @(negedge clk_sys);
    ptr_load = 1'b0;
    ptr_inc = 1'b0;
    pm[sel] = ld ? int'(v) : (pm[sel] + 1) % 65536;
    @(negedge clk_sys);
    chk("data_pointer", 16'(pm[sel]), data_pointer);
  endtask

  // Data move with length, strobe width, address and read data measured
  task automatic do_move(input bit wr, input bit up, input logic [15:0] ad, input logic [7:0] wd, input int s);
    int n;
    int w;
    int i;
    logic [15:0] seen;
    @(negedge clk_sys);
    move_write = wr;
    move_use_ptr = up;
    {move_page, move_reg_addr} = up ? ~ad : ad;
    move_wdata = wd;
    move_req = 1'b1;
    i = 0;
    while (!move_busy && i < 20)
    begin
      @(negedge clk_sys);
      i++;
    end
    move_req = 1'b0;
    n = 0;
    w = 0;
    seen = 16'h0000;
    while (!move_done && n < 60)
    begin
      if (ale)
        seen = {high_port_out, low_port_out};
      if (!rd_n || !wr_n)
        w++;
      n++;
      @(negedge clk_sys);
    end
    chk("move_len", 16'(4 * (s + 2)), 16'(n));
    chk("strobe_width", 16'(s == 0 ? 2 : 4 * s), 16'(w));
    chk("move_addr", ad, seen);
    if (wr)
      em[ad[7:0]] = wd;
    else
      chk("move_rdata", 16'(em[ad[7:0]]), {8'h00, move_rdata});
  endtask

  task automatic do_fetch(input logic [15:0] fa);
    int n;
    int w;
    @(negedge clk_sys);
    fetch_addr = fa;
    fetch_req = 1'b1;
    n = 0;
    w = 0;
    while (!fetch_done && n < 20)
    begin
      if (!psen_n)
        w++;
      n++;
      @(negedge clk_sys);
    end
    fetch_req = 1'b0;
    chk("psen_width", 16'h0002, 16'(w));
    chk("fetch_data", {8'h00, fa[7:0] ^ fa[15:8] ^ 8'h3C}, {8'h00, fetch_data});
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    {reset_n, sfr_wr, sfr_rd, ptr_load, ptr_inc, move_req, move_write, move_use_ptr, fetch_req, slow} = '0;
    {sfr_addr, sfr_wdata, move_page, move_reg_addr, move_wdata, ptr_load_value, fetch_addr} = '0;
    void'($urandom(19));
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    reset_n = 1'b1;
    for (int k = 0; k < 5; k++)
      sfr_r(sdma_pkg::ADDR_PTR0_LOW + 8'(k), 0);
    sfr_r(sdma_pkg::ADDR_CLOCK_CONTROL, 1);
    sfr_r(8'h90, 0);
    do_move(1'b1, 1'b0, 16'h1234, 8'h5A, 1);
    for (int k = 0; k < 4; k++)
    begin
      pb[k] = int'(8'($urandom));
      sfr_w(sdma_pkg::ADDR_PTR0_LOW + 8'(k), 8'(pb[k]));
    end
    for (int k = 0; k < 4; k++)
      sfr_r(sdma_pkg::ADDR_PTR0_LOW + 8'(k), pb[k]);
    pm[0] = pb[1] * 256 + pb[0];
    pm[1] = pb[3] * 256 + pb[2];
    sfr_w(sdma_pkg::ADDR_PTR_SELECT, 8'hFF);
    sel = 1;
    sfr_r(sdma_pkg::ADDR_PTR_SELECT, 1);
    ptr_op(1'b1, 16'hFFFF);
    ptr_op(1'b0, 16'h0000);
    sfr_w(sdma_pkg::ADDR_PTR_SELECT, 8'(sel + 1));
    sel = 0;
    ptr_op(1'b0, 16'h0000);
    for (int k = 0; k < 4; k++)
      sfr_r(sdma_pkg::ADDR_PTR0_LOW + 8'(k), (pm[k / 2] >> (8 * (k % 2))) % 256);
    for (int s = 0; s < 8; s++)
    begin
      sfr_w(sdma_pkg::ADDR_CLOCK_CONTROL, 8'(s));
      sfr_r(sdma_pkg::ADDR_CLOCK_CONTROL, s);
      a = 16'($urandom);
      d = 8'($urandom);
      slow = s > 2;
      if (s % 2 == 1)
        ptr_op(1'b1, a);
      do_move(1'b1, 1'(s % 2), a, d, s);
      fork
        do_move(1'b0, 1'(s % 2), a, 8'h00, s);
        begin
          repeat (6) @(negedge clk_sys);
          sfr_w(sdma_pkg::ADDR_CLOCK_CONTROL, 8'(7 - s));
        end
      join
    end
    sfr_w(sdma_pkg::ADDR_CLOCK_CONTROL, 8'h07);
    do_fetch(16'(($urandom)));
    finish_test();
  end

  // Watchdog against a hung handshake
  initial
  begin
    #100000;
    bad_count++;
    finish_test();
  end
endmodule

`default_nettype wire
